// ---- rtl/rps_top.sv ----
// rps_top: remappable pin select, two input selects and four output remaps
// assumes: single 10 MHz clock, synchronous active-high reset, simple register port
//
// Behaviour
// - Each input select is a 7-bit code; code zero ties the peripheral input low and unassigned codes route no pin.
// - Codes one to four pick comparators one to four, and codes six and seven pick pattern trigger outputs 30 and 31.
// - Codes eight and nine pick the encoder index and home inputs, only on variants that carry the encoder.
// - The first output remap register holds the pin 38 function in bits 5-0 and the pin 39 function in bits 13-8.
// - The second output remap register holds the pin 41 function in bits 13-8, and all such fields reset to zero.
// - The second output remap register holds the pin 40 function in bits 5-0, readable and writable.
// - Bits 15-14 and 7-6 of each output remap register ignore writes and read as zero.
//
// The address map and the plain strobed port were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module rps_top #(
	parameter logic HAS_ENCODER = 1'b1
) (
	// clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_clk_en,
	// register port
	input  wire rps_pkg::rps_bus_s     i_bus,
	output logic [15:0]                o_rdata,
	// internal sources and pin levels
	input  wire rps_pkg::rps_internal_s i_internal,
	input  wire rps_pkg::rps_pin_vec_t  i_pins,
	// peripheral output functions, indexed by function number
	input  wire logic [63:0]           i_fn_out,
	input  wire logic [63:0]           i_fn_oe,
	// peripheral inputs
	output logic [1:0]                 o_periph_in,
	// remappable pins 38 to 41
	output logic [3:0]                 o_pin_out,
	output logic [3:0]                 o_pin_oe
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] rps_pack_remap(input logic [5:0] hi, input logic [5:0] lo);
		logic [15:0] v;
		v = 16'h0000;
		v[rps_pkg::RPS_HI_FIELD_L +: rps_pkg::RPS_FN_W] = hi;
		v[rps_pkg::RPS_LO_FIELD_L +: rps_pkg::RPS_FN_W] = lo;
		return v & rps_pkg::RPS_OUT_REMAP_MASK;
	endfunction : rps_pack_remap

	function automatic logic [5:0] rps_field(input logic [15:0] w, input logic hi);
		logic [5:0] f;
		f = hi ? w[rps_pkg::RPS_HI_FIELD_L +: rps_pkg::RPS_FN_W]
		       : w[rps_pkg::RPS_LO_FIELD_L +: rps_pkg::RPS_FN_W];
		return f;
	endfunction : rps_field

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [5:0]  fn_reg [rps_pkg::RPS_NUM_OUT_PINS];
	logic [5:0]  fn_next [rps_pkg::RPS_NUM_OUT_PINS];
	logic [6:0]  sel_reg [rps_pkg::RPS_NUM_IN_SEL];
	logic [6:0]  sel_next [rps_pkg::RPS_NUM_IN_SEL];
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [1:0]  sel_level;
	logic [1:0]  sel_valid;

	always_comb begin
		fn_next  = fn_reg;
		sel_next = sel_reg;
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				rps_pkg::RPS_ADDR_OUT_REMAP_2: begin
					fn_next[0] = rps_field(i_bus.wdata, 1'b0);
					fn_next[1] = rps_field(i_bus.wdata, 1'b1);
				end
				rps_pkg::RPS_ADDR_OUT_REMAP_3: begin
					fn_next[2] = rps_field(i_bus.wdata, 1'b0);
					fn_next[3] = rps_field(i_bus.wdata, 1'b1);
				end
				rps_pkg::RPS_ADDR_IN_SEL_0: sel_next[0] = i_bus.wdata[rps_pkg::RPS_SEL_W-1:0];
				rps_pkg::RPS_ADDR_IN_SEL_1: sel_next[1] = i_bus.wdata[rps_pkg::RPS_SEL_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_next = 16'h0000;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				rps_pkg::RPS_ADDR_OUT_REMAP_2: rdata_next = rps_pack_remap(fn_reg[1], fn_reg[0]);
				rps_pkg::RPS_ADDR_OUT_REMAP_3: rdata_next = rps_pack_remap(fn_reg[3], fn_reg[2]);
				rps_pkg::RPS_ADDR_IN_SEL_0:    rdata_next = {9'h000, sel_reg[0]};
				rps_pkg::RPS_ADDR_IN_SEL_1:    rdata_next = {9'h000, sel_reg[1]};
				rps_pkg::RPS_ADDR_IN_STATE:    rdata_next = {12'h000, sel_valid, sel_level};
				default:                       rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < rps_pkg::RPS_NUM_OUT_PINS; i++) begin
				fn_reg[i] <= rps_pkg::RPS_FN_NONE;
			end
			for (int i = 0; i < rps_pkg::RPS_NUM_IN_SEL; i++) begin
				sel_reg[i] <= rps_pkg::RPS_SEL_RST;
			end
			rdata_reg <= 16'h0000;
		end else if (i_clk_en) begin
			fn_reg    <= fn_next;
			sel_reg   <= sel_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// input select path
	// ----------------------------------------------------------------
	for (genvar g = 0; g < rps_pkg::RPS_NUM_IN_SEL; g++) begin : g_in
		rps_in_sel u_sel (
			.i_code        (sel_reg[g]),
			.i_internal    (i_internal),
			.i_pins        (i_pins),
			.i_has_encoder (HAS_ENCODER),
			.o_level       (sel_level[g]),
			.o_valid       (sel_valid[g])
		);
	end

	logic [1:0] periph_reg;
	logic [1:0] periph_next;

	always_comb begin
		periph_next = sel_level & sel_valid;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			periph_reg <= 2'h0;
		end else if (i_clk_en) begin
			periph_reg <= periph_next;
		end
	end

	assign o_periph_in = periph_reg;

	// ----------------------------------------------------------------
	// output remap path
	// ----------------------------------------------------------------
	logic [3:0] pin_out_reg;
	logic [3:0] pin_out_next;
	logic [3:0] pin_oe_reg;
	logic [3:0] pin_oe_next;

	always_comb begin
		pin_out_next = 4'h0;
		pin_oe_next  = 4'h0;
		for (int i = 0; i < rps_pkg::RPS_NUM_OUT_PINS; i++) begin
			// function zero leaves the pin undriven by the remap
			if (fn_reg[i] != rps_pkg::RPS_FN_NONE) begin
				pin_out_next[i] = i_fn_out[fn_reg[i]];
				pin_oe_next[i]  = i_fn_oe[fn_reg[i]];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			pin_out_reg <= 4'h0;
			pin_oe_reg  <= 4'h0;
		end else if (i_clk_en) begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg  <= pin_oe_next;
		end
	end

	assign o_pin_out = pin_out_reg;
	assign o_pin_oe  = pin_oe_reg;

endmodule : rps_top

`default_nettype wire

// ---- rtl/rps_pkg.sv ----
// rps_pkg: constants and types for the remappable pin select block
// assumes: used by rtl/rps_top.sv and rtl/rps_in_sel.sv, no import, scoped use only

package rps_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] RPS_ADDR_OUT_REMAP_2 = 4'h0;
	localparam logic [3:0] RPS_ADDR_OUT_REMAP_3 = 4'h1;
	localparam logic [3:0] RPS_ADDR_IN_SEL_0    = 4'h2;
	localparam logic [3:0] RPS_ADDR_IN_SEL_1    = 4'h3;
	localparam logic [3:0] RPS_ADDR_IN_STATE    = 4'h4;

	localparam int RPS_NUM_IN_SEL = 2;

	// ----------------------------------------------------------------
	// field layout of the output remap registers
	// ----------------------------------------------------------------
	localparam int RPS_FN_W       = 6;
	localparam int RPS_LO_FIELD_L = 0;
	localparam int RPS_HI_FIELD_L = 8;
	localparam logic [15:0] RPS_OUT_REMAP_MASK = 16'h3F3F;
	localparam logic [15:0] RPS_OUT_REMAP_RST  = 16'h0000;

	// input select register: code in bits 6-0
	localparam int RPS_SEL_W = 7;
	localparam logic [6:0] RPS_SEL_RST = 7'h00;

	// ----------------------------------------------------------------
	// input select codes
	// ----------------------------------------------------------------
	localparam logic [6:0] RPS_CODE_TIE_LOW  = 7'h00;
	localparam logic [6:0] RPS_CODE_CMP1     = 7'h01;
	localparam logic [6:0] RPS_CODE_CMP2     = 7'h02;
	localparam logic [6:0] RPS_CODE_CMP3     = 7'h03;
	localparam logic [6:0] RPS_CODE_CMP4     = 7'h04;
	localparam logic [6:0] RPS_CODE_PTG30    = 7'h06;
	localparam logic [6:0] RPS_CODE_PTG31    = 7'h07;
	localparam logic [6:0] RPS_CODE_ENC_IDX  = 7'h08;
	localparam logic [6:0] RPS_CODE_ENC_HOM  = 7'h09;
	localparam logic [6:0] RPS_CODE_IO_PIN20 = 7'h14;
	localparam logic [6:0] RPS_CODE_IN_PIN24 = 7'h18;
	localparam logic [6:0] RPS_CODE_IN_PIN25 = 7'h19;
	localparam logic [6:0] RPS_CODE_IN_PIN27 = 7'h1B;
	localparam logic [6:0] RPS_CODE_IN_PIN28 = 7'h1C;
	localparam logic [6:0] RPS_CODE_IN_PIN32 = 7'h20;
	localparam logic [6:0] RPS_CODE_IN_PIN33 = 7'h21;
	localparam logic [6:0] RPS_CODE_IN_PIN34 = 7'h22;
	localparam logic [6:0] RPS_CODE_IO_PIN35 = 7'h23;
	localparam logic [6:0] RPS_CODE_IO_PIN36 = 7'h24;
	localparam logic [6:0] RPS_CODE_IO_PIN37 = 7'h25;
	localparam logic [6:0] RPS_CODE_IO_PIN38 = 7'h26;
	localparam logic [6:0] RPS_CODE_IO_PIN39 = 7'h27;
	localparam logic [6:0] RPS_CODE_IN_PIN45 = 7'h2D;
	localparam logic [6:0] RPS_CODE_IN_PIN46 = 7'h2E;
	localparam logic [6:0] RPS_CODE_IN_PIN47 = 7'h2F;
	localparam logic [6:0] RPS_CODE_IN_PIN51 = 7'h33;
	localparam logic [6:0] RPS_CODE_IN_PIN52 = 7'h34;
	localparam logic [6:0] RPS_CODE_IN_PIN53 = 7'h35;
	localparam logic [6:0] RPS_CODE_IO_PIN54 = 7'h36;
	localparam logic [6:0] RPS_CODE_IO_PIN55 = 7'h37;
	localparam logic [6:0] RPS_CODE_IO_PIN56 = 7'h38;
	localparam logic [6:0] RPS_CODE_IO_PIN57 = 7'h39;
	localparam logic [6:0] RPS_CODE_IN_PIN58 = 7'h3A;

	// output function code that leaves a pin to its plain port latch
	localparam logic [5:0] RPS_FN_NONE = 6'h00;
	localparam int RPS_NUM_FN = 64;
	localparam int RPS_NUM_OUT_PINS = 4;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic comparator_one_output;
		logic comparator_two_output;
		logic comparator_three_output;
		logic comparator_four_output;
		logic pattern_trigger_out_30;
		logic pattern_trigger_out_31;
		logic encoder_index_input;
		logic encoder_home_input;
	} rps_internal_s;

	// remappable pin input levels, one bit per pin number
	typedef logic [63:0] rps_pin_vec_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} rps_bus_s;

endpackage : rps_pkg

// ---- rtl/rps_in_sel.sv ----
// rps_in_sel: decodes one 7-bit input select code into a source level
// assumes: internal signals and pin levels are synchronous to the caller's clock

`timescale 1ns/1ps
`default_nettype none

module rps_in_sel (
	// select code
	input  wire logic [6:0]            i_code,
	// sources
	input  wire rps_pkg::rps_internal_s i_internal,
	input  wire rps_pkg::rps_pin_vec_t  i_pins,
	input  wire logic                  i_has_encoder,
	// result
	output logic                       o_level,
	output logic                       o_valid
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		o_level = 1'b0;
		o_valid = 1'b1;
		unique case (i_code)
			rps_pkg::RPS_CODE_TIE_LOW: o_level = 1'b0;
			rps_pkg::RPS_CODE_CMP1:    o_level = i_internal.comparator_one_output;
			rps_pkg::RPS_CODE_CMP2:    o_level = i_internal.comparator_two_output;
			rps_pkg::RPS_CODE_CMP3:    o_level = i_internal.comparator_three_output;
			rps_pkg::RPS_CODE_CMP4:    o_level = i_internal.comparator_four_output;
			rps_pkg::RPS_CODE_PTG30:   o_level = i_internal.pattern_trigger_out_30;
			rps_pkg::RPS_CODE_PTG31:   o_level = i_internal.pattern_trigger_out_31;
			rps_pkg::RPS_CODE_ENC_IDX: begin
				o_level = i_has_encoder & i_internal.encoder_index_input;
				o_valid = i_has_encoder;
			end
			rps_pkg::RPS_CODE_ENC_HOM: begin
				o_level = i_has_encoder & i_internal.encoder_home_input;
				o_valid = i_has_encoder;
			end
			rps_pkg::RPS_CODE_IO_PIN20, rps_pkg::RPS_CODE_IN_PIN24, rps_pkg::RPS_CODE_IN_PIN25,
			rps_pkg::RPS_CODE_IN_PIN27, rps_pkg::RPS_CODE_IN_PIN28, rps_pkg::RPS_CODE_IN_PIN32,
			rps_pkg::RPS_CODE_IN_PIN33, rps_pkg::RPS_CODE_IN_PIN34, rps_pkg::RPS_CODE_IO_PIN35,
			rps_pkg::RPS_CODE_IO_PIN36, rps_pkg::RPS_CODE_IO_PIN37, rps_pkg::RPS_CODE_IO_PIN38,
			rps_pkg::RPS_CODE_IO_PIN39, rps_pkg::RPS_CODE_IN_PIN45, rps_pkg::RPS_CODE_IN_PIN46,
			rps_pkg::RPS_CODE_IN_PIN47, rps_pkg::RPS_CODE_IN_PIN51, rps_pkg::RPS_CODE_IN_PIN52,
			rps_pkg::RPS_CODE_IN_PIN53, rps_pkg::RPS_CODE_IO_PIN54, rps_pkg::RPS_CODE_IO_PIN55,
			rps_pkg::RPS_CODE_IO_PIN56, rps_pkg::RPS_CODE_IO_PIN57, rps_pkg::RPS_CODE_IN_PIN58:
				o_level = i_pins[i_code[5:0]];
			default: begin
				// unimplemented code: no pin routed, input held low
				o_level = 1'b0;
				o_valid = 1'b0;
			end
		endcase
	end

endmodule : rps_in_sel

`default_nettype wire

// ---- dv/rps_far_model.sv ----
// rps_far_model: peripherals and package pins around the remap block
// assumes: bench clock, seed already set by the bench

`timescale 1ns/1ps
`default_nettype none

module rps_far_model (
	// clock
	input  wire logic                  i_ref_clk,
	// levels toward the block
	output var rps_pkg::rps_internal_s o_internal,
	output var rps_pkg::rps_pin_vec_t  o_pins,
	output var logic [63:0]            o_fn_out,
	output var logic [63:0]            o_fn_oe
);
	// fresh levels every cycle so a stale route shows
	initial begin
		{o_internal, o_pins, o_fn_out, o_fn_oe} = '0;
	end
	always @(posedge i_ref_clk) begin
		o_internal <= 8'($urandom);
		o_pins     <= {$urandom, $urandom};
		o_fn_out   <= {$urandom, $urandom};
		o_fn_oe    <= {$urandom, $urandom};
	end
endmodule : rps_far_model

`default_nettype wire

// ---- dv/rps_top_properties.sv ----
// rps_top_properties: port assertions of rps_top
// assumes: bound into rps_top, one clock domain

`timescale 1ns/1ps
`default_nettype none

module rps_top_properties #(
	parameter logic HAS_ENCODER = 1'b1
) (
	input wire logic                   i_ref_clk,
	input wire logic                   i_sys_rst,
	input wire logic                   i_clk_en,
	input wire rps_pkg::rps_bus_s      i_bus,
	input wire logic [15:0]            o_rdata,
	input wire rps_pkg::rps_internal_s i_internal,
	input wire rps_pkg::rps_pin_vec_t  i_pins,
	input wire logic [63:0]            i_fn_out,
	input wire logic [63:0]            i_fn_oe,
	input wire logic [1:0]             o_periph_in,
	input wire logic [3:0]             o_pin_out,
	input wire logic [3:0]             o_pin_oe
);
	logic        en_q;
	default clocking cb @(posedge i_ref_clk); endclocking
	// the cycle after a frozen one still shows frozen outputs beside fresh sources
	default disable iff (i_sys_rst || !i_clk_en || !en_q);
	always_ff @(posedge i_ref_clk) begin
		en_q <= i_sys_rst | i_clk_en;
	end
	// ----
	// shadow of the fields
	// ----
	logic [15:0] map0_q, map1_q;
	logic [6:0]  sel_q;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			map0_q <= 16'h0000;
			map1_q <= 16'h0000;
			sel_q  <= 7'h00;
		end else if (i_clk_en && i_bus.wr) begin
			if (i_bus.addr == 4'h0) map0_q <= i_bus.wdata & 16'h3F3F;
			if (i_bus.addr == 4'h1) map1_q <= i_bus.wdata & 16'h3F3F;
			if (i_bus.addr == 4'h2) sel_q <= i_bus.wdata[6:0];
		end
	end
	sequence s_write(a); i_bus.wr && i_bus.addr == a; endsequence
	sequence s_read(a); i_bus.rd && i_bus.addr == a; endsequence
	chk_tie_low: assert property ($past(sel_q) == 7'h00 |-> !o_periph_in[0])
		else $error("tie low code not low");
	chk_cmp_route: assert property ($past(sel_q) inside {[7'h01:7'h04]}
		|-> o_periph_in[0] == $past(i_internal[4'd8 - sel_q[3:0]])) else $error("comparator route");
	chk_trig_route: assert property ($past(sel_q) inside {7'h06, 7'h07}
		|-> o_periph_in[0] == $past(i_internal[4'd9 - sel_q[3:0]])) else $error("trigger route");
	chk_enc_route: assert property ($past(sel_q) inside {7'h08, 7'h09}
		|-> o_periph_in[0] == (HAS_ENCODER && $past(i_internal[4'd9 - sel_q[3:0]]))) else $error("encoder route");
	chk_unimpl_low: assert property ($past(sel_q) inside {7'h05, [7'h0A:7'h13], [7'h15:7'h17], 7'h1A,
		[7'h1D:7'h1F], [7'h28:7'h2C], [7'h30:7'h32], [7'h3B:7'h7F]}
		|-> !o_periph_in[0]) else $error("unimplemented code not low");
	chk_freeze_hold: assert property (disable iff (i_sys_rst) !i_clk_en |=> $stable(o_rdata) && $stable(o_periph_in)
		&& $stable(o_pin_out) && $stable(o_pin_oe)) else $error("outputs moved while frozen");
	chk_map_readback: assert property (s_write(4'h1) ##1 s_read(4'h1)
		|=> o_rdata == ($past(i_bus.wdata, 2) & 16'h3F3F)) else $error("remap readback");
	chk_rsvd_zero: assert property (s_read(4'h0) or s_read(4'h1) |=> (o_rdata & 16'hC0C0) == 16'h0000)
		else $error("reserved bits not zero");
	chk_pin38_map: assert property ($past(map0_q[5:0]) != 6'h00 |-> o_pin_out[0] == $past(i_fn_out[map0_q[5:0]])
		&& o_pin_oe[0] == $past(i_fn_oe[map0_q[5:0]])) else $error("pin 38 function");
	chk_pin41_map: assert property ($past(map1_q[13:8]) != 6'h00 |-> o_pin_out[3] == $past(i_fn_out[map1_q[13:8]])
		&& o_pin_oe[3] == $past(i_fn_oe[map1_q[13:8]])) else $error("pin 41 function");
	chk_pin40_idle: assert property ($past(map1_q[5:0]) == 6'h00 |-> !o_pin_oe[2] && !o_pin_out[2])
		else $error("pin 40 driven without function");
	chk_reset_idle: assert property ($fell(i_sys_rst) |-> o_pin_oe == 4'h0 ##1 o_pin_oe == 4'h0)
		else $error("pin driven after reset");
endmodule : rps_top_properties

bind rps_top rps_top_properties #(.HAS_ENCODER(HAS_ENCODER)) chk_u (.i_ref_clk, .i_sys_rst, .i_clk_en, .i_bus,
	.o_rdata, .i_internal, .i_pins, .i_fn_out, .i_fn_oe, .o_periph_in, .o_pin_out, .o_pin_oe);

`default_nettype wire

// ---- dv/rps_top_test.sv ----
// rps_top_test: self-checking bench for rps_top against a reference model
// assumes: rps_far_model drives the sources, checker bound to the design

`timescale 1ns/1ps
`default_nettype none

module rps_top_test;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   en = 1'b1;
	rps_pkg::rps_bus_s      bus = '0;
	rps_pkg::rps_internal_s internal;
	rps_pkg::rps_pin_vec_t  pins;
	logic [63:0]            fn_out, fn_oe;
	logic [15:0]            rdata;
	logic [1:0]             pin_in, exp_in = '0;
	logic [1:0]             pin_ne, exp_ne = '0;
	logic [15:0]            exp_w = '0;
	logic [3:0]             pout, poe;
	logic [7:0]             exp_pin = '0;
	int                     n_fail = 0, total_checks = 0, f;
	int                     sel_m[2], map_m[2], exp_q[$];

	always #50 clk = ~clk;
	rps_far_model far_u (.i_ref_clk(clk), .o_internal(internal), .o_pins(pins), .o_fn_out(fn_out), .o_fn_oe(fn_oe));
	rps_top #(.HAS_ENCODER(1'b1)) dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_bus(bus),
		.o_rdata(rdata), .i_internal(internal), .i_pins(pins), .i_fn_out(fn_out), .i_fn_oe(fn_oe),
		.o_periph_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe));
	// variant without the encoder, only its routed inputs are compared
	rps_top #(.HAS_ENCODER(1'b0)) dut_ne_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_bus(bus),
		.o_rdata(), .i_internal(internal), .i_pins(pins), .i_fn_out(fn_out), .i_fn_oe(fn_oe),
		.o_periph_in(pin_ne), .o_pin_out(), .o_pin_oe());

	// ----
	// reference model, checked every cycle
	// ----
	function automatic logic src(int c, bit enc);
		if (c inside {[1:4]}) return internal[8 - c];
		if (c inside {[6:7]}) return internal[9 - c];
		if (c inside {[8:9]}) return enc & internal[9 - c];
		if (c inside {20, 24, 25, 27, 28, [32:39], [45:47], [51:58]}) return pins[c];
		return 1'b0;
	endfunction : src
	function automatic logic vld(int c, bit enc);
		return (c inside {[0:4], [6:7], 20, 24, 25, 27, 28, [32:39], [45:47], [51:58]}) || (enc && c inside {[8:9]});
	endfunction : vld
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_lvl
	always @(posedge clk) begin
		if (rst) begin
			sel_m = '{0, 0};
			map_m = '{0, 0};
			exp_q.delete();
			exp_in = '0;
			exp_ne = '0;
			exp_w = '0;
			exp_pin = '0;
		end else begin
			cmp_word(rdata, exp_w);
			cmp_lvl({6'h00, pin_in}, {6'h00, exp_in});
			cmp_lvl({6'h00, pin_ne}, {6'h00, exp_ne});
			cmp_lvl({pout, poe}, exp_pin);
			// a frozen cycle keeps every output, so expectations stand too
			if (en) begin
				exp_in = {src(sel_m[1], 1'b1), src(sel_m[0], 1'b1)};
				exp_ne = {src(sel_m[1], 1'b0), src(sel_m[0], 1'b0)};
				for (int p = 0; p < 4; p++) begin
					f = (map_m[p / 2] >> (p % 2 * 8)) & 63;
					exp_pin[p + 4] = f ? fn_out[f] : 1'b0;
					exp_pin[p] = f ? fn_oe[f] : 1'b0;
				end
				if (bus.rd) exp_q.push_back(bus.addr < 2 ? map_m[bus.addr] : bus.addr < 4 ? sel_m[bus.addr - 2] :
					bus.addr == 4 ? int'({vld(sel_m[1], 1'b1), vld(sel_m[0], 1'b1),
					src(sel_m[1], 1'b1), src(sel_m[0], 1'b1)}) : 0);
				exp_w = 16'(exp_q.size() ? exp_q.pop_front() : 0);
				if (bus.wr && bus.addr < 2) map_m[bus.addr] = bus.wdata & 16'h3F3F;
				if (bus.wr && bus.addr inside {2, 3}) sel_m[bus.addr - 2] = bus.wdata[6:0];
			end
		end
	end

	// ----
	// bus driver and verdict
	// ----
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
	endtask : acc
	task automatic idle(input int n);
		bus <= '0;
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	initial begin
		void'($urandom(5919));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		acc(1'b0, 4'h0, 16'h0000);
		acc(1'b0, 4'h1, 16'h0000);
		acc(1'b1, 4'h0, 16'hFFFF);
		acc(1'b0, 4'h0, 16'h0000);
		acc(1'b1, 4'hF, 16'hFFFF);
		acc(1'b0, 4'hF, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			acc(1'b1, 4'(i % 2), 16'($urandom));
			acc(1'b0, 4'(i % 2), 16'h0000);
			if (i % 4 == 3) begin
				// freeze while the read data stand
				en <= 1'b0;
				idle(3);
				en <= 1'b1;
			end
			idle(2);
		end
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		acc(1'b0, 4'h0, 16'h0000);
		acc(1'b0, 4'h1, 16'h0000);
		for (int c = 0; c < 128; c++) begin
			acc(1'b1, 4'h2, {9'($urandom), 7'(c)});
			acc(1'b1, 4'h3, 16'(127 - c));
			acc(1'b0, 4'h2, 16'h0000);
			acc(1'b0, 4'h4, 16'h0000);
			idle(2);
		end
		idle(3);
		conclude();
	end
endmodule : rps_top_test

`default_nettype wire
